/* hw/vpm_cfg.svh */
// register offsets, field positions, reset values and timing for vpm
`ifndef VPM_CFG_SVH
`define VPM_CFG_SVH
// word indices of the registers (byte address is the printed index times four)
`define VPM_IDX_MODE 4'h0
`define VPM_IDX_BYP 4'h1
`define VPM_IDX_RXG 4'h2
`define VPM_IDX_TXG 4'h3
`define VPM_IDX_LEC 4'h4
`define VPM_IDX_AHI 4'h6
`define VPM_IDX_ALO 4'h7
`define VPM_IDX_DHI 4'h8
`define VPM_IDX_DLO 4'h9
`define VPM_IDX_SYNC 4'hb
`define VPM_IDX_LAST 4'hc
// mode register fields
`define VPM_MODE_PDN 7
`define VPM_MODE_ENMSK 8'h3c
// general bypass register fields
`define VPM_BYP_WR 7
`define VPM_BYP_PAD 2
`define VPM_BYP_SLP 1
`define VPM_BYP_NC 0
`define VPM_BYP_MSK 8'h87
// gain and line fields
`define VPM_GAIN_MSK 8'h3f
`define VPM_GAIN_MUTE 6'h2b
`define VPM_LEC_MSK 8'h9f
`define VPM_LEC_THR 7
`define VPM_LEC_HD 4
`define VPM_LEC_CLP 3
`define VPM_LEC_HLD 2
`define VPM_LEC_ATT 1
`define VPM_LEC_GC 0
// sync register fields
`define VPM_SYNC_RDY 7
`define VPM_SYNC_MSK 8'h03
`define VPM_RST8 8'h00
// timing, in ms, and clock rate in kHz
`define VPM_CLK_KHZ 100000
`define VPM_INIT_MS 200
`define VPM_DROP_MS 20
`define VPM_ACOU_DLY_MS 44
`define VPM_LINE_DLY_MS 15
`endif

/* hw/vpm_pkg.sv */
// types shared by the vpm control block
package vpm_pkg;
    typedef enum logic [3:0] {
        VPM_ST_WAKE = 4'b0001,
        VPM_ST_INIT = 4'b0010,
        VPM_ST_DUAL = 4'b0100,
        VPM_ST_SING = 4'b1000
    } vpm_state_t;
    typedef logic [7:0] vpm_byte_t;
endpackage : vpm_pkg

/* hw/vpm_timer.sv */
// down-counting one-shot timer used for wake-up and dropout
`timescale 1ns/1ps
`default_nettype none
module vpm_timer #(
    parameter int CYCLES = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    // control
    input wire logic start,
    output logic busy,
    output logic done
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] cnt_q;
    logic busy_q;

    initial
    begin
        if (CYCLES < 1)
            $error("vpm_timer: CYCLES must be at least one");
    end

    // counter loads on start, counts to zero; clr aborts at once
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end
        else if (clr)
        begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end
        else if (start)
        begin
            cnt_q <= W'(CYCLES - 1);
            busy_q <= 1'b1;
        end
        else if (busy_q)
        begin
            if (cnt_q == '0)
                busy_q <= 1'b0;
            else
                cnt_q <= cnt_q - 1'b1;
        end
    end

    assign busy = busy_q;
    assign done = busy_q && (cnt_q == '0) && !start && !clr;
endmodule : vpm_timer
`default_nettype wire

/* hw/vpm_regs.sv */
// mode, bypass, gain and line canceler control registers on apb
`timescale 1ns/1ps
`default_nettype none
`include "vpm_cfg.svh"
module vpm_regs #(
    parameter int INIT_CYCLES =
        `VPM_INIT_MS * `VPM_CLK_KHZ,
    parameter int DROP_CYCLES =
        `VPM_DROP_MS * `VPM_CLK_KHZ
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // strap and bypass pins, asynchronous
    input wire logic pdn_rst_n_pin,
    input wire logic host_select_pin,
    input wire logic canceler_select_pin,
    input wire logic pad_bypass_pin,
    input wire logic slope_filter_bypass_pin,
    input wire logic noise_canceler_bypass_pin,
    input wire logic line_canceler_bypass_pin,
    input wire logic line_howl_detect_off_pin,
    input wire logic line_coeff_hold_pin,
    input wire logic line_attenuator_off_pin,
    input wire logic line_gain_ctrl_off_pin,
    // mode and status
    output vpm_pkg::vpm_state_t mode_state,
    output logic in_initial,
    output logic dig_out_tristate,
    output logic dig_in_idle,
    output logic cancelers_run,
    output logic [5:0] acoustic_delay_ms,
    output logic [5:0] line_delay_ms,
    // memory write port
    output logic mem_wr,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_data,
    // effective controls
    output logic pad_apply,
    output logic slope_filter_bypass,
    output logic noise_canceler_bypass,
    output logic noise_dropout,
    output logic [5:0] receive_gain_code,
    output logic receive_mute,
    output logic [5:0] transmit_gain_code,
    output logic transmit_mute,
    output logic line_canceler_bypass,
    output logic line_howl_detect_off,
    output logic line_center_clip_on,
    output logic line_coeff_hold,
    output logic line_attenuator_off,
    output logic line_gain_ctrl_off,
    output logic [3:0] if_enables
);
    import vpm_pkg::*;

    localparam int NPIN = 11;

    initial
    begin
        if (INIT_CYCLES < 1 || DROP_CYCLES < 1)
            $error("vpm_regs: timing counts must be at least one");
    end

    // two-flop synchronisers for every pin
    logic [NPIN-1:0] pin_raw, pin_m_q, pin_s_q;
    assign pin_raw = {pdn_rst_n_pin, host_select_pin, canceler_select_pin,
        pad_bypass_pin, slope_filter_bypass_pin, noise_canceler_bypass_pin,
        line_canceler_bypass_pin, line_howl_detect_off_pin,
        line_coeff_hold_pin, line_attenuator_off_pin,
        line_gain_ctrl_off_pin};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_sync
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    pin_m_q[gi] <= 1'b0;
                    pin_s_q[gi] <= 1'b0;
                end
                else
                begin
                    pin_m_q[gi] <= pin_raw[gi];
                    pin_s_q[gi] <= pin_m_q[gi];
                end
            end
        end
    endgenerate

    logic s_pdn_n, s_hsel, s_csel, s_pad, s_slp, s_nc;
    logic s_line_canceler_bypass, s_lhd, s_line_coeff_hold, s_line_attenuator_off, s_lgc;
    assign {s_pdn_n, s_hsel, s_csel, s_pad, s_slp, s_nc,
        s_line_canceler_bypass, s_lhd, s_line_coeff_hold, s_line_attenuator_off, s_lgc} = pin_s_q;

    // registers
    vpm_byte_t mode_q, byp_q, rxg_q, txg_q, lec_q;
    vpm_byte_t ahi_q, alo_q, dhi_q, dlo_q, sync_q;
    vpm_state_t state_q, state_d;

    // apb decode: one-cycle answer, no wait states
    logic acc, wr, rd, hit;
    logic [3:0] idx;
    assign acc = psel && penable;
    assign idx = paddr[5:2];
    assign hit = (paddr[31:6] == '0) && (paddr[1:0] == 2'b00)
        && (idx <= `VPM_IDX_LAST) && (idx != 4'h5) && (idx != 4'ha);
    assign wr = acc && pwrite && hit;
    assign rd = acc && !pwrite && hit;
    assign pready = 1'b1;
    assign pslverr = acc && !hit;

    logic init_m;
    assign init_m = (state_q == VPM_ST_INIT);

    // power-down reset from pin or register bit clears registers
    logic soft_pdn;
    assign soft_pdn = !s_pdn_n || mode_q[`VPM_MODE_PDN];

    // mode register; enable bits only while in initial mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_q <= `VPM_RST8;
        else if (wr && idx == `VPM_IDX_MODE)
        begin
            mode_q[`VPM_MODE_PDN] <= pwdata[`VPM_MODE_PDN];
            if (!soft_pdn)
            begin
                if (init_m)
                    mode_q[5:2] <= pwdata[5:2];
                mode_q[6] <= pwdata[6];
                mode_q[1:0] <= pwdata[1:0];
            end
        end
        else if (soft_pdn)
            mode_q[6:0] <= 7'h00;
    end

    // bypass register; write bit honoured only in initial mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            byp_q <= `VPM_RST8;
        else if (soft_pdn)
            byp_q <= `VPM_RST8;
        else if (wr && idx == `VPM_IDX_BYP)
        begin
            byp_q <= pwdata[7:0] & `VPM_BYP_MSK;
            byp_q[`VPM_BYP_WR] <= pwdata[`VPM_BYP_WR] && init_m;
        end
        else
            byp_q[`VPM_BYP_WR] <= 1'b0; // write bit self-clears
    end

    // gain, line and memory staging registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rxg_q <= `VPM_RST8;
            txg_q <= `VPM_RST8;
            lec_q <= `VPM_RST8;
            ahi_q <= `VPM_RST8;
            alo_q <= `VPM_RST8;
            dhi_q <= `VPM_RST8;
            dlo_q <= `VPM_RST8;
            sync_q <= `VPM_RST8;
        end
        else if (soft_pdn)
        begin
            rxg_q <= `VPM_RST8;
            txg_q <= `VPM_RST8;
            lec_q <= `VPM_RST8;
            ahi_q <= `VPM_RST8;
            alo_q <= `VPM_RST8;
            dhi_q <= `VPM_RST8;
            dlo_q <= `VPM_RST8;
            sync_q <= `VPM_RST8;
        end
        else if (wr)
        begin
            case (idx)
                `VPM_IDX_RXG: rxg_q <= pwdata[7:0] & `VPM_GAIN_MSK;
                `VPM_IDX_TXG: txg_q <= pwdata[7:0] & `VPM_GAIN_MSK;
                `VPM_IDX_LEC: lec_q <= pwdata[7:0] & `VPM_LEC_MSK;
                `VPM_IDX_AHI: ahi_q <= pwdata[7:0];
                `VPM_IDX_ALO: alo_q <= pwdata[7:0];
                `VPM_IDX_DHI: dhi_q <= pwdata[7:0];
                `VPM_IDX_DLO: dlo_q <= pwdata[7:0];
                `VPM_IDX_SYNC:
                    if (init_m)
                        sync_q <= pwdata[7:0] & `VPM_SYNC_MSK;
                default: ;
            endcase
        end
    end

    // wake-up timer runs from reset release to initial mode, or to dual or single mode when host select is set
    logic wake_start, wake_done, seen_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            seen_q <= 1'b0;
        else
            seen_q <= !soft_pdn;
    end
    assign wake_start = !soft_pdn && !seen_q;

    vpm_timer #(.CYCLES(INIT_CYCLES)) u_wake (
        .pclk(pclk),
        .presetn(presetn),
        .clr(soft_pdn),
        .start(wake_start),
        .busy(),
        .done(wake_done)
    );

    // effective mode code: register bits ORed with strap pins
    logic [1:0] eff_mode;
    assign eff_mode = mode_q[1:0] | {s_hsel, s_csel};

    function automatic vpm_state_t op_state(input logic [1:0] m);
        begin
            op_state = m[0] ? VPM_ST_SING : VPM_ST_DUAL;
        end
    endfunction : op_state

    // mode machine; no way back to initial except power-down
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            VPM_ST_WAKE:
                if (wake_done)
                    state_d = s_hsel ? op_state(eff_mode)
                        : VPM_ST_INIT;
            VPM_ST_INIT:
                if (eff_mode[1]) // reserved 01 is not a legal exit
                    state_d = op_state(eff_mode);
            VPM_ST_DUAL, VPM_ST_SING:
                if (eff_mode[1])
                    state_d = op_state(eff_mode);
            default: state_d = VPM_ST_WAKE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= VPM_ST_WAKE;
        else if (soft_pdn)
            state_q <= VPM_ST_WAKE;
        else
            state_q <= state_d;
    end

    // memory write strobe and word, sampled from staging registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_wr <= 1'b0;
            mem_addr <= 16'h0000;
            mem_data <= 16'h0000;
        end
        else
        begin
            mem_wr <= byp_q[`VPM_BYP_WR] && init_m;
            if (byp_q[`VPM_BYP_WR] && init_m)
            begin
                mem_addr <= {ahi_q, alo_q};
                mem_data <= {dhi_q, dlo_q};
            end
        end
    end

    // dropout when noise canceler goes back to normal
    logic nc_eff, nc_prev_q;
    assign nc_eff = byp_q[`VPM_BYP_NC] | s_nc;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            nc_prev_q <= 1'b0;
        else
            nc_prev_q <= nc_eff;
    end

    vpm_timer #(.CYCLES(DROP_CYCLES)) u_drop (
        .pclk(pclk),
        .presetn(presetn),
        .clr(soft_pdn),
        .start(nc_prev_q && !nc_eff),
        .busy(noise_dropout),
        .done()
    );

    // read mux; ready flag reflects initial mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            prdata <= 32'h0000_0000;
            case (idx)
                `VPM_IDX_MODE: prdata[7:0] <= mode_q;
                `VPM_IDX_BYP: prdata[7:0] <= byp_q;
                `VPM_IDX_RXG: prdata[7:0] <= rxg_q;
                `VPM_IDX_TXG: prdata[7:0] <= txg_q;
                `VPM_IDX_LEC: prdata[7:0] <= lec_q;
                `VPM_IDX_AHI: prdata[7:0] <= ahi_q;
                `VPM_IDX_ALO: prdata[7:0] <= alo_q;
                `VPM_IDX_DHI: prdata[7:0] <= dhi_q;
                `VPM_IDX_DLO: prdata[7:0] <= dlo_q;
                `VPM_IDX_SYNC: prdata[7:0] <=
                    sync_q | {init_m, 7'h00};
                default: ;
            endcase
        end
    end

    // effective outputs; bypass and line canceler bits ORed with synchronised pins, except center clip
    assign mode_state = state_q;
    assign in_initial = init_m;
    assign dig_out_tristate = (state_q == VPM_ST_INIT)
        || (state_q == VPM_ST_WAKE);
    assign dig_in_idle = dig_out_tristate;
    assign cancelers_run = !dig_out_tristate;
    assign acoustic_delay_ms = (state_q == VPM_ST_DUAL) ?
        6'(`VPM_ACOU_DLY_MS) : 6'h00;
    assign line_delay_ms = (state_q == VPM_ST_DUAL) ?
        6'(`VPM_LINE_DLY_MS) : 6'h00;
    assign pad_apply = byp_q[`VPM_BYP_PAD] | s_pad;
    assign slope_filter_bypass = byp_q[`VPM_BYP_SLP] | s_slp;
    assign noise_canceler_bypass = nc_eff;
    assign receive_gain_code = rxg_q[5:0];
    assign receive_mute = (rxg_q[5:0] == `VPM_GAIN_MUTE);
    assign transmit_gain_code = txg_q[5:0];
    assign transmit_mute = (txg_q[5:0] == `VPM_GAIN_MUTE);
    assign line_canceler_bypass = lec_q[`VPM_LEC_THR] | s_line_canceler_bypass;
    assign line_howl_detect_off = lec_q[`VPM_LEC_HD] | s_lhd;
    assign line_center_clip_on = lec_q[`VPM_LEC_CLP];
    assign line_coeff_hold = lec_q[`VPM_LEC_HLD] | s_line_coeff_hold;
    assign line_attenuator_off = lec_q[`VPM_LEC_ATT] | s_line_attenuator_off;
    assign line_gain_ctrl_off = lec_q[`VPM_LEC_GC] | s_lgc;
    assign if_enables = mode_q[5:2];
endmodule : vpm_regs
`default_nettype wire

/* sim/vpm_host_pins.sv */
// board strap and bypass pins as set by the host side
`timescale 1ns/1ps
`default_nettype none
module vpm_host_pins (
    // requests from the bench
    input wire logic pclk,
    input wire logic [1:0] mode_req,
    input wire logic [7:0] byp_req,
    input wire logic pdn_req,
    // strap pins
    output logic pdn_rst_n_pin,
    output logic host_select_pin,
    output logic canceler_select_pin,
    output logic pad_bypass_pin,
    output logic slope_filter_bypass_pin,
    output logic noise_canceler_bypass_pin,
    output logic line_canceler_bypass_pin,
    output logic line_howl_detect_off_pin,
    output logic line_coeff_hold_pin,
    output logic line_attenuator_off_pin,
    output logic line_gain_ctrl_off_pin
);
    // pins move only after a rising clock edge
    always_ff @(posedge pclk)
    begin
        pdn_rst_n_pin <= !pdn_req;
        {host_select_pin, canceler_select_pin} <= mode_req;
        {pad_bypass_pin, slope_filter_bypass_pin, noise_canceler_bypass_pin,
         line_canceler_bypass_pin, line_howl_detect_off_pin,
         line_coeff_hold_pin, line_attenuator_off_pin,
         line_gain_ctrl_off_pin} <= byp_req;
    end
endmodule : vpm_host_pins
`default_nettype wire

/* sim/vpm_regs_monitor.sv */
// assertion checker for the vpm control registers
`timescale 1ns/1ps
`default_nettype none
module vpm_regs_monitor
import vpm_pkg::*;
#(
    parameter int INIT_CYCLES = 20
) (
    // apb side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    // pins
    input wire logic host_select_pin,
    input wire logic pad_bypass_pin,
    // status and controls
    input wire vpm_pkg::vpm_state_t mode_state,
    input wire logic in_initial,
    input wire logic dig_out_tristate,
    input wire logic dig_in_idle,
    input wire logic cancelers_run,
    input wire logic [5:0] acoustic_delay_ms,
    input wire logic [5:0] line_delay_ms,
    input wire logic mem_wr,
    input wire logic pad_apply,
    input wire logic noise_canceler_bypass,
    input wire logic noise_dropout,
    input wire logic [5:0] receive_gain_code,
    input wire logic receive_mute
);
    logic [15:0] wake_cnt_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // wake length counter, bounds the start-up wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wake_cnt_q <= 16'h0000;
        else if (mode_state == VPM_ST_WAKE)
            wake_cnt_q <= wake_cnt_q + 16'h0001;
        else
            wake_cnt_q <= 16'h0000;
    end
    sequence s_wr_rx;
        psel && penable && pwrite && paddr == 32'h0000_0008;
    endsequence
    sequence s_wake_exit;
        (host_select_pin && mode_state == VPM_ST_WAKE)
        ##1 (mode_state != VPM_ST_WAKE);
    endsequence
    property p_wake_len;
        mode_state == VPM_ST_WAKE |-> wake_cnt_q < INIT_CYCLES + 16;
    endproperty
    property p_wake_min;
        mode_state == VPM_ST_INIT && $past(mode_state) == VPM_ST_WAKE
        |-> $past(wake_cnt_q) >= INIT_CYCLES - 1;
    endproperty
    property p_init_flags;
        in_initial |-> dig_out_tristate && dig_in_idle && !cancelers_run;
    endproperty
    property p_dual_dly;
        mode_state == VPM_ST_DUAL [*2]
        |-> acoustic_delay_ms == 6'h2c && line_delay_ms == 6'h0f;
    endproperty
    property p_no_return;
        mode_state inside {VPM_ST_DUAL, VPM_ST_SING}
        |=> mode_state != VPM_ST_INIT;
    endproperty
    property p_host_skip;
        s_wake_exit |-> mode_state != VPM_ST_INIT;
    endproperty
    property p_rx_mute;
        $stable(receive_gain_code)
        |-> receive_mute == (receive_gain_code == 6'h2b);
    endproperty
    property p_wr_rx;
        s_wr_rx |=> receive_gain_code == $past(pwdata[5:0]);
    endproperty
    property p_memwr;
        mem_wr |-> in_initial;
    endproperty
    property p_dropout;
        $fell(noise_canceler_bypass) |-> ##[0:2] noise_dropout;
    endproperty
    property p_pad_pin;
        pad_bypass_pin [*4] |-> pad_apply;
    endproperty
    a_wake_len: assert property (p_wake_len)
        else $error("wake phase too long");
    a_wake_min: assert property (p_wake_min)
        else $error("wake phase too short");
    a_init_flags: assert property (p_init_flags)
        else $error("initial mode flags wrong");
    a_dual_dly: assert property (p_dual_dly)
        else $error("dual mode delays wrong");
    a_no_return: assert property (p_no_return)
        else $error("returned to initial without reset");
    a_host_skip: assert property (p_host_skip)
        else $error("initial not skipped with host select");
    a_rx_mute: assert property (p_rx_mute)
        else $error("receive mute mismatch");
    a_wr_rx: assert property (p_wr_rx)
        else $error("receive gain not written");
    a_memwr: assert property (p_memwr)
        else $error("memory write outside initial");
    a_dropout: assert property (p_dropout)
        else $error("no dropout after noise bypass release");
    a_pad_pin: assert property (p_pad_pin)
        else $error("pad pin not ORed in");
endmodule : vpm_regs_monitor
bind vpm_regs vpm_regs_monitor #(.INIT_CYCLES(INIT_CYCLES))
    vpm_regs_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .host_select_pin, .pad_bypass_pin, .mode_state,
    .in_initial, .dig_out_tristate, .dig_in_idle, .cancelers_run,
    .acoustic_delay_ms, .line_delay_ms, .mem_wr, .pad_apply,
    .noise_canceler_bypass, .noise_dropout, .receive_gain_code,
    .receive_mute);
`default_nettype wire

/* sim/vpm_regs_tb_top.sv */
// self-checking bench for the vpm control registers
`timescale 1ns/1ps
`default_nettype none
module vpm_regs_tb_top;
import vpm_pkg::*;
localparam int INIT_N = 20;
localparam int DROP_N = 10;
typedef struct {
    logic [7:0] a, wd;
    logic [5:0] rx, tx, lec;
    logic [2:0] byp;
} vpm_row_t;
logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr, hit;
logic [31:0] paddr, pwdata, prdata, rd, cap;
logic pdn_rst_n_pin, host_select_pin, canceler_select_pin, pad_bypass_pin;
logic slope_filter_bypass_pin, noise_canceler_bypass_pin;
logic line_canceler_bypass_pin, line_howl_detect_off_pin;
logic line_coeff_hold_pin, line_attenuator_off_pin, line_gain_ctrl_off_pin;
vpm_state_t mode_state;
logic in_initial, dig_out_tristate, dig_in_idle, cancelers_run, mem_wr;
logic [5:0] acoustic_delay_ms, line_delay_ms;
logic [5:0] receive_gain_code, transmit_gain_code;
logic [15:0] mem_addr, mem_data;
logic pad_apply, slope_filter_bypass, noise_canceler_bypass, noise_dropout;
logic receive_mute, transmit_mute, line_canceler_bypass;
logic line_howl_detect_off, line_center_clip_on, line_coeff_hold;
logic line_attenuator_off, line_gain_ctrl_off;
logic [3:0] if_enables;
logic [1:0] mode_req;
logic [7:0] byp_req;
logic pdn_req;
int err_total, n_checks, cyc_n, i;
vpm_row_t rows [7];
vpm_regs #(.INIT_CYCLES(INIT_N), .DROP_CYCLES(DROP_N)) vpm_regs_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pdn_rst_n_pin, .host_select_pin,
    .canceler_select_pin, .pad_bypass_pin, .slope_filter_bypass_pin,
    .noise_canceler_bypass_pin, .line_canceler_bypass_pin,
    .line_howl_detect_off_pin, .line_coeff_hold_pin,
    .line_attenuator_off_pin, .line_gain_ctrl_off_pin, .mode_state,
    .in_initial, .dig_out_tristate, .dig_in_idle, .cancelers_run,
    .acoustic_delay_ms, .line_delay_ms, .mem_wr, .mem_addr, .mem_data,
    .pad_apply, .slope_filter_bypass, .noise_canceler_bypass,
    .noise_dropout, .receive_gain_code, .receive_mute, .transmit_gain_code,
    .transmit_mute, .line_canceler_bypass, .line_howl_detect_off,
    .line_center_clip_on, .line_coeff_hold, .line_attenuator_off,
    .line_gain_ctrl_off, .if_enables);
vpm_host_pins vpm_host_pins_inst (.pclk, .mode_req, .byp_req, .pdn_req,
    .pdn_rst_n_pin, .host_select_pin, .canceler_select_pin,
    .pad_bypass_pin, .slope_filter_bypass_pin, .noise_canceler_bypass_pin,
    .line_canceler_bypass_pin, .line_howl_detect_off_pin,
    .line_coeff_hold_pin, .line_attenuator_off_pin,
    .line_gain_ctrl_off_pin);
task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e)
    begin
        err_total++;
        $display("ERROR %s expected %h seen %h", nm, e, s);
    end
endtask : chk
task automatic tally_and_finish();
    if (err_total == 0 && n_checks > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask : tally_and_finish
// one apb transfer; waits on pready rather than assuming a latency
task automatic apb(input logic wr, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
        @(posedge pclk);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask : apb
task automatic rdchk(input logic [31:0] a, e);
    apb(1'b0, a, 32'h0);
    chk("readback", rd, e);
endtask : rdchk
task automatic wait_st(input vpm_state_t s, input int lim);
    int n;
    n = 0;
    @(posedge pclk);
    #1;
    while (mode_state !== s && n < lim)
    begin
        @(posedge pclk);
        #1;
        n++;
    end
    chk("mode_state", {28'h0, mode_state}, {28'h0, s});
endtask : wait_st
// looks for a memory write pulse a few cycles after the trigger
task automatic pulse();
    hit = 1'b0;
    repeat (4)
    begin
        @(posedge pclk);
        #1;
        if (mem_wr === 1'b1)
        begin
            hit = 1'b1;
            cap = {mem_addr, mem_data};
        end
    end
endtask : pulse
function automatic logic [31:0] obs();
    return {9'h0, receive_mute, receive_gain_code, transmit_mute,
        transmit_gain_code, line_canceler_bypass, line_howl_detect_off,
        line_center_clip_on, line_coeff_hold, line_attenuator_off,
        line_gain_ctrl_off, pad_apply, slope_filter_bypass,
        noise_canceler_bypass};
endfunction : obs
function automatic logic [31:0] eobs(input vpm_row_t r);
    return {9'h0, r.rx == 6'h2b, r.rx, r.tx == 6'h2b, r.tx, r.lec, r.byp};
endfunction : eobs
initial
begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
end
// hang guard, well above the expected run length
always @(posedge pclk)
begin
    cyc_n++;
    if (cyc_n == 4000)
    begin
        err_total++;
        tally_and_finish();
    end
end
initial
begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {mode_req, byp_req, pdn_req, err_total, n_checks, cyc_n} = '0;
    rows = '{'{8'h08, 8'h2b, 6'h2b, 6'h00, 6'h00, 3'h0},
        '{8'h0c, 8'h2c, 6'h2b, 6'h2c, 6'h00, 3'h0},
        '{8'h08, 8'h2a, 6'h2a, 6'h2c, 6'h00, 3'h0},
        '{8'h0c, 8'h2b, 6'h2a, 6'h2b, 6'h00, 3'h0},
        '{8'h10, 8'h9f, 6'h2a, 6'h2b, 6'h3f, 3'h0},
        '{8'h04, 8'h07, 6'h2a, 6'h2b, 6'h3f, 3'h7},
        '{8'h10, 8'h00, 6'h2a, 6'h2b, 6'h00, 3'h7}};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk("wake", {28'h0, mode_state}, {28'h0, VPM_ST_WAKE});
    rdchk(32'h08, 32'h0);
    wait_st(VPM_ST_INIT, INIT_N + 12);
    chk("tristate", dig_out_tristate, 1'b1);
    rdchk(32'h2c, 32'h80);
    apb(1'b1, 32'h00, 32'h3d);
    wait_st(VPM_ST_INIT, 2);
    chk("enables", if_enables, 4'hf);
    apb(1'b1, 32'h18, 32'h12);
    apb(1'b1, 32'h1c, 32'h34);
    apb(1'b1, 32'h20, 32'h56);
    apb(1'b1, 32'h24, 32'h78);
    apb(1'b1, 32'h04, 32'h80);
    pulse();
    chk("mem_wr", hit, 1'b1);
    chk("mem_word", cap, 32'h1234_5678);
    for (i = 0; i < 7; i++)
    begin
        apb(1'b1, {24'h0, rows[i].a}, {24'h0, rows[i].wd});
        #1;
        chk("controls", obs(), eobs(rows[i]));
        rdchk({24'h0, rows[i].a}, {24'h0, rows[i].wd});
    end
    apb(1'b1, 32'h04, 32'h00);
    for (i = 0; i < 4 && noise_dropout !== 1'b1; i++)
        @(negedge pclk);
    chk("dropout_on", noise_dropout, 1'b1);
    repeat (DROP_N - 3) @(negedge pclk);
    chk("dropout_held", noise_dropout, 1'b1);
    repeat (6) @(negedge pclk);
    chk("dropout_off", noise_dropout, 1'b0);
    @(posedge pclk);
    byp_req <= 8'hff;
    repeat (5) @(posedge pclk);
    #1;
    chk("pins", obs(), eobs('{0, 0, 6'h2a, 6'h2b, 6'h37, 3'h7}));
    @(posedge pclk);
    byp_req <= 8'h00;
    apb(1'b1, 32'h00, 32'h02);
    wait_st(VPM_ST_DUAL, 4);
    chk("delays", {acoustic_delay_ms, line_delay_ms}, 12'hb0f);
    chk("run", {dig_out_tristate, cancelers_run}, 2'b01);
    rdchk(32'h2c, 32'h00);
    apb(1'b1, 32'h04, 32'h80);
    pulse();
    chk("mem_wr_refused", hit, 1'b0);
    apb(1'b1, 32'h00, 32'h00);
    wait_st(VPM_ST_DUAL, 2);
    apb(1'b1, 32'h00, 32'h3f);
    wait_st(VPM_ST_SING, 4);
    rdchk(32'h00, 32'h03);
    rdchk(32'h14, 32'h0);
    chk("pslverr", serr, 1'b1);
    apb(1'b1, 32'h00, 32'h80);
    wait_st(VPM_ST_WAKE, 4);
    rdchk(32'h08, 32'h0);
    apb(1'b1, 32'h00, 32'h00);
    wait_st(VPM_ST_INIT, INIT_N + 12);
    apb(1'b1, 32'h08, 32'h05);
    pdn_req <= 1'b1;
    wait_st(VPM_ST_WAKE, 6);
    rdchk(32'h08, 32'h0);
    pdn_req <= 1'b0;
    @(posedge pclk);
    mode_req <= 2'b10;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wait_st(VPM_ST_DUAL, INIT_N + 12);
    tally_and_finish();
end
endmodule : vpm_regs_tb_top
`default_nettype wire
